// >>> hdl/fpe_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash program/erase control
//
// Behaviour
// - Start bit sets only while armed and right after the unlock key pair.
// - Start launches the selected operation; hardware clears start when it finishes.
// - Device reset returns only the arm bit of the control register.
// - Arm enables start writes and powers the supply-low detector; clear disables both.
// - Read-only error flag is set when a program or erase fails.
// - Supply-low error flag is set when supply dips during an operation, detector on.
// - Supply-low live status follows the detector while it is powered.
// - Operation select is written only while arm is zero.
// - Code 0001 programs one word at the target address unless protected.
// - Code 0011 programs the row at the target address unless protected.
// - Code 0100 erases the page at the target address unless protected.
// - Code 0101 erases the whole array only when no page is protected.
// - Launching with code 0000 clears the error and supply-low error flags.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH

`define FPE_OFS_CTRL        12'h000
`define FPE_OFS_KEY         12'h010
`define FPE_OFS_ADDR        12'h020
`define FPE_OFS_IRQ_STAT    12'h030
`define FPE_OFS_IRQ_CLR     12'h034
`define FPE_OFS_IRQ_EN      12'h038

`define FPE_BIT_START       15
`define FPE_BIT_ARM         14
`define FPE_BIT_ERR         13
`define FPE_BIT_LOWERR      12
`define FPE_BIT_LOWLIVE     11
`define FPE_OP_MSB          3
`define FPE_OP_LSB          0

`define FPE_IRQ_DONE        0
`define FPE_IRQ_ERR         1
`define FPE_IRQ_LOW         2

`define FPE_KEY_FIRST       32'hAA996655
`define FPE_KEY_SECOND      32'h556699AA

`define FPE_RST_CTRL        32'h00000000
`define FPE_RST_ADDR        32'h00000000
`define FPE_RST_IRQ_EN      3'h0

`define FPE_CLK_PERIOD_PS   8000
`define FPE_OP_TIMEOUT_US   2000
`define FPE_OP_TIMEOUT_CYC  ((`FPE_OP_TIMEOUT_US * 1000000) / `FPE_CLK_PERIOD_PS)

`endif

// >>> hdl/fpe_pkg.sv
// Types of the flash program/erase control
package fpe_pkg;

    typedef enum logic [3:0] {
        FPE_OP_NONE0  = 4'h0,
        FPE_OP_WORD   = 4'h1,
        FPE_OP_NONE2  = 4'h2,
        FPE_OP_ROW    = 4'h3,
        FPE_OP_PAGE   = 4'h4,
        FPE_OP_ARRAY  = 4'h5,
        FPE_OP_NONE6  = 4'h6
    } fpe_op_t;

    typedef enum logic [1:0] {
        FPE_ST_IDLE  = 2'b00,
        FPE_ST_CHECK = 2'b01,
        FPE_ST_RUN   = 2'b10,
        FPE_ST_DONE  = 2'b11
    } fpe_state_t;

    typedef struct packed {
        logic        req;
        logic [3:0]  op;
        logic [31:0] addr;
    } fpe_flash_cmd_t;

    typedef struct packed {
        logic done;
        logic fail;
    } fpe_flash_rsp_t;

endpackage

// >>> hdl/fpe_timer.sv
// Operation watchdog: loads a cycle count and flags expiry
`timescale 1ns/1ps
module fpe_timer #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Control
    input  wire logic             load,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] load_value,
    // Status
    output logic                  expired
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             zero;

    if (CNT_W < 1) begin : g_bad_width
        $error("fpe_timer: width below one bit");
    end

    assign zero      = (count_ff == '0);
    assign nxt_count = load ? load_value : ((run && !zero) ? count_ff - 1'b1 : count_ff);
    assign expired   = run && zero;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule

// >>> hdl/fpe_ctrl.sv
// Flash program/erase control: APB registers, unlock, sequencer and interrupt
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_ctrl #(
    parameter int ADDR_W      = 32,
    parameter int ROW_SHIFT   = 7,
    parameter int PAGE_SHIFT  = 10,
    parameter int PAGE_W      = 8,
    parameter int TIMEOUT_CYC = `FPE_OP_TIMEOUT_CYC
) (
    // Clock and resets
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   device_reset,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // Flash array side
    output fpe_pkg::fpe_flash_cmd_t     flash_cmd,
    input  wire fpe_pkg::fpe_flash_rsp_t flash_rsp,
    input  wire logic [PAGE_W-1:0]      protect_pages,
    // Supply-low detector
    output logic                        detector_enable,
    input  wire logic                   supply_low,
    // Interrupt
    output logic                        irq
);
    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

    if (ADDR_W > 32 || ADDR_W <= PAGE_SHIFT || ROW_SHIFT > PAGE_SHIFT) begin : g_bad_geometry
        $error("fpe_ctrl: address geometry not supported");
    end
    if (TIMEOUT_CYC < 1) begin : g_bad_timeout
        $error("fpe_ctrl: timeout must be at least one cycle");
    end

    // Page index of a flash address
    function automatic logic [ADDR_W-1:0] page_of(input logic [ADDR_W-1:0] a);
        page_of = a >> PAGE_SHIFT;
    endfunction

    // Pages below the protect boundary are write-protected
    function automatic logic is_protected(input logic [ADDR_W-1:0] a,
                                          input logic [PAGE_W-1:0] bound);
        is_protected = (page_of(a) < ADDR_W'(bound));
    endfunction

    // Register state
    logic                   start_ff;
    logic                   arm_ff;
    logic                   err_ff;
    logic                   lowerr_ff;
    logic [3:0]             op_ff;
    logic [ADDR_W-1:0]      addr_ff;
    logic                   key1_seen_ff;
    logic                   unlocked_ff;
    logic [2:0]             irq_stat_ff;
    logic [2:0]             irq_en_ff;
    logic [31:0]            prdata_ff;
    logic                   pslverr_ff;
    fpe_pkg::fpe_state_t    state_ff;
    fpe_pkg::fpe_flash_cmd_t cmd_ff;

    logic                   nxt_start;
    logic                   nxt_arm;
    logic                   nxt_err;
    logic                   nxt_lowerr;
    logic [3:0]             nxt_op;
    fpe_pkg::fpe_state_t    nxt_state;
    logic [2:0]             nxt_irq_stat;

    // APB decode
    logic        setup;
    logic        wr_access;
    logic        hit_ctrl;
    logic        hit_key;
    logic        hit_addr;
    logic        hit_stat;
    logic        hit_clr;
    logic        hit_en;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_key;
    logic        wr_addr;
    logic        wr_clr;
    logic        wr_en;
    logic [31:0] ctrl_view;
    logic [31:0] rd_mux;

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign hit_ctrl  = (paddr == `FPE_OFS_CTRL);
    assign hit_key   = (paddr == `FPE_OFS_KEY);
    assign hit_addr  = (paddr == `FPE_OFS_ADDR);
    assign hit_stat  = (paddr == `FPE_OFS_IRQ_STAT);
    assign hit_clr   = (paddr == `FPE_OFS_IRQ_CLR);
    assign hit_en    = (paddr == `FPE_OFS_IRQ_EN);
    assign mapped    = hit_ctrl || hit_key || hit_addr || hit_stat || hit_clr || hit_en;
    assign wr_ctrl   = wr_access && hit_ctrl;
    assign wr_key    = wr_access && hit_key;
    assign wr_addr   = wr_access && hit_addr;
    assign wr_clr    = wr_access && hit_clr;
    assign wr_en     = wr_access && hit_en;

    // Supply-low detector runs only while armed
    assign detector_enable = arm_ff;

    // Live status tracks the detector with no storage
    logic lowlive;
    assign lowlive = arm_ff && supply_low;

    always_comb begin
        ctrl_view                    = 32'h00000000;
        ctrl_view[`FPE_BIT_START]    = start_ff;
        ctrl_view[`FPE_BIT_ARM]      = arm_ff;
        ctrl_view[`FPE_BIT_ERR]      = err_ff;
        ctrl_view[`FPE_BIT_LOWERR]   = lowerr_ff;
        ctrl_view[`FPE_BIT_LOWLIVE]  = lowlive;
        ctrl_view[`FPE_OP_MSB:`FPE_OP_LSB] = op_ff;
    end

    assign rd_mux = hit_ctrl ? ctrl_view :
                    hit_addr ? 32'(addr_ff) :
                    hit_stat ? {29'h0000000, irq_stat_ff} :
                    hit_en   ? {29'h0000000, irq_en_ff} :
                    32'h00000000;

    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // Read data and error captured in the setup phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_ff <= !mapped;
        end
    end

    // Unlock: first key then second key, consumed by the next write to any register
    logic key_first;
    logic key_second;
    assign key_first  = wr_key && (pwdata == `FPE_KEY_FIRST);
    assign key_second = wr_key && (pwdata == `FPE_KEY_SECOND) && key1_seen_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key1_seen_ff <= 1'b0;
            unlocked_ff  <= 1'b0;
        end else begin
            key1_seen_ff <= wr_key ? key_first : (wr_access ? 1'b0 : key1_seen_ff);
            unlocked_ff  <= key_second ? 1'b1 : (wr_access ? 1'b0 : unlocked_ff);
        end
    end

    // Operation classification
    logic [3:0] op_run;
    logic       op_word;
    logic       op_row;
    logic       op_page;
    logic       op_array;
    logic       op_clear;
    logic       op_touches;
    logic       prot_hit;
    logic [ADDR_W-1:0] word_addr;
    logic [ADDR_W-1:0] row_addr;
    logic [ADDR_W-1:0] page_addr;

    assign op_run     = op_ff;
    assign op_word    = (op_run == fpe_pkg::FPE_OP_WORD);
    assign op_row     = (op_run == fpe_pkg::FPE_OP_ROW);
    assign op_page    = (op_run == fpe_pkg::FPE_OP_PAGE);
    assign op_array   = (op_run == fpe_pkg::FPE_OP_ARRAY);
    assign op_clear   = (op_run == fpe_pkg::FPE_OP_NONE0);
    assign op_touches = op_word || op_row || op_page || op_array;
    assign word_addr  = addr_ff;
    assign row_addr   = (addr_ff >> ROW_SHIFT) << ROW_SHIFT;
    assign page_addr  = (addr_ff >> PAGE_SHIFT) << PAGE_SHIFT;
    assign prot_hit   = op_array ? (protect_pages != '0) :
                        is_protected(addr_ff, protect_pages);

    // Operation watchdog
    logic timer_load;
    logic timer_run;
    logic timer_expired;
    logic launch;

    assign timer_run = (state_ff == fpe_pkg::FPE_ST_RUN);

    fpe_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clock      (clock),
        .rst        (rst),
        .load       (timer_load),
        .run        (timer_run),
        .load_value (CNT_W'(TIMEOUT_CYC)),
        .expired    (timer_expired)
    );

    // Start may be set only while armed and unlocked
    assign launch = wr_ctrl && pwdata[`FPE_BIT_START] && arm_ff && unlocked_ff
                    && !start_ff;

    // Sequencer
    logic seq_fail;
    logic seq_finish;

    always_comb begin
        nxt_state  = state_ff;
        timer_load = 1'b0;
        seq_fail   = 1'b0;
        seq_finish = 1'b0;
        case (state_ff)
            fpe_pkg::FPE_ST_IDLE: begin
                if (launch) begin
                    nxt_state = fpe_pkg::FPE_ST_CHECK;
                end
            end
            fpe_pkg::FPE_ST_CHECK: begin
                if (!op_touches) begin
                    nxt_state = fpe_pkg::FPE_ST_DONE;
                end else if (prot_hit) begin
                    seq_fail  = 1'b1;
                    nxt_state = fpe_pkg::FPE_ST_DONE;
                end else begin
                    timer_load = 1'b1;
                    nxt_state  = fpe_pkg::FPE_ST_RUN;
                end
            end
            fpe_pkg::FPE_ST_RUN: begin
                if (flash_rsp.done) begin
                    seq_fail  = flash_rsp.fail;
                    nxt_state = fpe_pkg::FPE_ST_DONE;
                end else if (timer_expired) begin
                    seq_fail  = 1'b1;
                    nxt_state = fpe_pkg::FPE_ST_DONE;
                end
            end
            fpe_pkg::FPE_ST_DONE: begin
                seq_finish = 1'b1;
                nxt_state  = fpe_pkg::FPE_ST_IDLE;
            end
            default: begin
                nxt_state = fpe_pkg::FPE_ST_IDLE;
            end
        endcase
    end

    // Command to the array, held for the whole run
    fpe_pkg::fpe_flash_cmd_t nxt_cmd;
    always_comb begin
        nxt_cmd = cmd_ff;
        if (timer_load) begin
            nxt_cmd.req  = 1'b1;
            nxt_cmd.op   = op_run;
            nxt_cmd.addr = 32'(op_word ? word_addr :
                               op_row  ? row_addr  :
                               op_page ? page_addr : '0);
        end else if (nxt_state != fpe_pkg::FPE_ST_RUN) begin
            nxt_cmd.req = 1'b0;
        end
    end
    assign flash_cmd = cmd_ff;

    // Control register next values
    logic low_event;
    assign low_event = lowlive && (state_ff == fpe_pkg::FPE_ST_RUN);

    always_comb begin
        nxt_start  = start_ff;
        nxt_arm    = arm_ff;
        nxt_err    = err_ff;
        nxt_lowerr = lowerr_ff;
        nxt_op     = op_ff;
        if (launch) begin
            nxt_start = 1'b1;
            if (op_clear) begin
                nxt_err    = 1'b0;
                nxt_lowerr = 1'b0;
            end
        end
        if (seq_finish) begin
            nxt_start = 1'b0;
        end
        if (wr_ctrl) begin
            nxt_arm = pwdata[`FPE_BIT_ARM];
            if (!arm_ff) begin
                nxt_op = pwdata[`FPE_OP_MSB:`FPE_OP_LSB];
            end
        end
        if (seq_fail) begin
            nxt_err = 1'b1;
        end
        if (low_event) begin
            nxt_lowerr = 1'b1;
        end
        if (device_reset) begin
            nxt_arm = 1'b0;
        end
    end

    // Sticky interrupt causes; a new event wins over a clear
    logic [2:0] irq_events;
    assign irq_events[`FPE_IRQ_DONE] = seq_finish;
    assign irq_events[`FPE_IRQ_ERR]  = seq_fail;
    assign irq_events[`FPE_IRQ_LOW]  = low_event && !lowerr_ff;
    assign nxt_irq_stat = (irq_stat_ff & ~(wr_clr ? pwdata[2:0] : 3'h0)) | irq_events;
    assign irq          = |(irq_stat_ff & irq_en_ff);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_ff    <= 1'(`FPE_RST_CTRL >> `FPE_BIT_START);
            arm_ff      <= 1'b0;
            err_ff      <= 1'b0;
            lowerr_ff   <= 1'b0;
            op_ff       <= 4'h0;
            state_ff    <= fpe_pkg::FPE_ST_IDLE;
            cmd_ff      <= '0;
            irq_stat_ff <= 3'h0;
        end else begin
            start_ff    <= nxt_start;
            arm_ff      <= nxt_arm;
            err_ff      <= nxt_err;
            lowerr_ff   <= nxt_lowerr;
            op_ff       <= nxt_op;
            state_ff    <= nxt_state;
            cmd_ff      <= nxt_cmd;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // Target address and interrupt enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_ff   <= ADDR_W'(`FPE_RST_ADDR);
            irq_en_ff <= `FPE_RST_IRQ_EN;
        end else begin
            if (wr_addr && !start_ff) begin
                addr_ff <= pwdata[ADDR_W-1:0];
            end
            if (wr_en) begin
                irq_en_ff <= pwdata[2:0];
            end
        end
    end
endmodule

// >>> testbench/fpe_ctrl_checker.sv
// Port-level assertions for the flash program/erase control
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_ctrl_checker #(
    parameter int ROW_SHIFT   = 7,
    parameter int PAGE_SHIFT  = 10,
    parameter int PAGE_W      = 8,
    parameter int TIMEOUT_CYC = 50
) (
    // Clock and resets
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic                    device_reset,
    // APB slave
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pslverr,
    // Flash array side
    input wire fpe_pkg::fpe_flash_cmd_t flash_cmd,
    input wire fpe_pkg::fpe_flash_rsp_t flash_rsp,
    input wire logic [PAGE_W-1:0]       protect_pages,
    // Detector and interrupt
    input wire logic                    detector_enable,
    input wire logic                    irq
);
    localparam int REQ_MAX = TIMEOUT_CYC + 4;
    wire logic              access   = psel && penable;
    wire logic              ctrl_wr  = access && pwrite && (paddr == `FPE_OFS_CTRL);
    wire logic              arm_bit  = pwdata[`FPE_BIT_ARM];
    wire logic              req      = flash_cmd.req;
    wire logic [PAGE_W-1:0] page_idx = flash_cmd.addr[PAGE_SHIFT +: PAGE_W];
    wire logic              mapped   = paddr inside {`FPE_OFS_CTRL, `FPE_OFS_KEY, `FPE_OFS_ADDR,
                                       `FPE_OFS_IRQ_STAT, `FPE_OFS_IRQ_CLR, `FPE_OFS_IRQ_EN};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_op_legal: assert property (req |-> flash_cmd.op inside {4'h1, 4'h3, 4'h4, 4'h5})
        else $error("flash command with a non-touching code");
    chk_page_free: assert property (req && flash_cmd.op != 4'h5 |-> page_idx >= protect_pages)
        else $error("flash command on a protected page");
    chk_array_free: assert property (req && flash_cmd.op == 4'h5 |-> protect_pages == '0 && flash_cmd.addr == '0)
        else $error("array erase while a page is protected");
    chk_row_align: assert property (req && flash_cmd.op == 4'h3 |-> flash_cmd.addr[ROW_SHIFT-1:0] == '0)
        else $error("row program address not aligned");
    chk_req_drop: assert property (req && flash_rsp.done |=> !req)
        else $error("request stays after done");
    chk_req_hold: assert property (req ##1 req |-> $stable(flash_cmd.op) && $stable(flash_cmd.addr))
        else $error("command changed while requested");
    chk_req_bound: assert property ($rose(req) |-> ##[1:REQ_MAX] !req)
        else $error("request never ends");
    chk_arm_detect: assert property (ctrl_wr && !device_reset |=> ##1 detector_enable == $past(arm_bit, 2))
        else $error("detector enable does not follow arm");
    chk_dev_reset: assert property (device_reset |-> ##2 !detector_enable)
        else $error("device reset left the detector on");
    chk_unmapped_err: assert property (access && !mapped |-> pslverr)
        else $error("no slave error on unmapped access");

    cover property ($rose(req) && flash_cmd.op == 4'h5);
    cover property ($rose(irq));
    cover property (access && !mapped);
endmodule

bind fpe_ctrl fpe_ctrl_checker #(.ROW_SHIFT(ROW_SHIFT), .PAGE_SHIFT(PAGE_SHIFT), .PAGE_W(PAGE_W),
    .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clock(clock), .rst(rst), .device_reset(device_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .flash_cmd(flash_cmd), .flash_rsp(flash_rsp),
    .protect_pages(protect_pages), .detector_enable(detector_enable), .irq(irq));

// >>> testbench/fpe_flash_model.sv
// Behavioural program flash array answering the sequencer's commands
`timescale 1ns/1ps
module fpe_flash_model (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // Command and response
    input  wire fpe_pkg::fpe_flash_cmd_t flash_cmd,
    output fpe_pkg::fpe_flash_rsp_t      flash_rsp,
    // Behaviour controls
    input  wire logic [3:0]              lat,
    input  wire logic                    fail_en,
    input  wire logic                    hang_en,
    // Record of accepted commands
    output logic [3:0]                   last_op,
    output logic [31:0]                  last_addr,
    output logic [7:0]                   op_count
);
    logic [3:0] cnt_ff;
    logic       busy_ff;

    // One command per request; the done cycle blocks a restart on the lagging request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff    <= 4'h0;
            busy_ff   <= 1'b0;
            flash_rsp <= '0;
            last_op   <= 4'h0;
            last_addr <= 32'h0;
            op_count  <= 8'h00;
        end else begin
            flash_rsp <= '0;
            if (flash_cmd.req && !busy_ff && !flash_rsp.done) begin
                busy_ff   <= 1'b1;
                cnt_ff    <= lat;
                last_op   <= flash_cmd.op;
                last_addr <= flash_cmd.addr;
                op_count  <= op_count + 8'h01;
            end else if (busy_ff && !flash_cmd.req) begin
                busy_ff <= 1'b0;
            end else if (busy_ff && !hang_en) begin
                if (cnt_ff == 4'h0) begin
                    busy_ff        <= 1'b0;
                    flash_rsp.done <= 1'b1;
                    flash_rsp.fail <= fail_en;
                end else begin
                    cnt_ff <= cnt_ff - 4'h1;
                end
            end
        end
    end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the flash program/erase control
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module tb;
    localparam logic [11:0] CTRL = `FPE_OFS_CTRL;
    localparam logic [11:0] IST  = `FPE_OFS_IRQ_STAT;
    logic                    clock, rst, device_reset, psel, penable, pwrite, pready, pslverr;
    logic                    detector_enable, supply_low, irq, fail_en, hang_en, rerr;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, rdata, last_addr, exp_a;
    logic [7:0]              protect_pages, op_count, n0;
    logic [3:0]              lat, last_op;
    fpe_pkg::fpe_flash_cmd_t flash_cmd;
    fpe_pkg::fpe_flash_rsp_t flash_rsp;
    int                      fail_count, cmp_count, cyc;

    fpe_ctrl #(.TIMEOUT_CYC(50)) dut (.clock(clock), .rst(rst), .device_reset(device_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .flash_cmd(flash_cmd),
        .flash_rsp(flash_rsp), .protect_pages(protect_pages), .detector_enable(detector_enable),
        .supply_low(supply_low), .irq(irq));
    fpe_flash_model u_flash (.clock(clock), .rst(rst), .flash_cmd(flash_cmd),
        .flash_rsp(flash_rsp), .lat(lat), .fail_en(fail_en), .hang_en(hang_en),
        .last_op(last_op), .last_addr(last_addr), .op_count(op_count));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Disarm, select the code while disarmed, arm, unlock, start, then poll start
    task automatic run_op(input logic [3:0] op);
        int n;
        n0 = op_count;
        wr(CTRL, 32'h0000);
        wr(CTRL, 32'h4000 | op);
        wr(`FPE_OFS_KEY, `FPE_KEY_FIRST);
        wr(`FPE_OFS_KEY, `FPE_KEY_SECOND);
        wr(CTRL, 32'hC000 | op);
        n = 0;
        do begin
            rd(CTRL);
            n++;
        end while (rdata[15] !== 1'b0 && n < 60);
        check("start_clear", {31'h0, rdata[15]}, 32'h0);
    endtask

    initial begin
        rst = 1'b1;
        {device_reset, psel, penable, pwrite, supply_low, fail_en, hang_en, rerr} = '0;
        {paddr, pwdata, rdata, protect_pages, n0} = '0;
        lat = 4'h2;
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(CTRL);
        check("ctrl_reset", rdata, `FPE_RST_CTRL);
        rd(`FPE_OFS_ADDR);
        check("addr_reset", rdata, `FPE_RST_ADDR);
        rd(`FPE_OFS_IRQ_EN);
        check("irq_en_reset", rdata, 32'h0);
        rd(12'h040);
        check("unmapped_err", {31'h0, rerr}, 32'h1);
        check("unmapped_data", rdata, 32'h0);
        $display("test reset_and_map done");

        wr(CTRL, 32'h0001);
        wr(CTRL, 32'h4003);
        wr(CTRL, 32'h4004);
        supply_low <= 1'b1;
        rd(CTRL);
        check("op_locked_live", rdata, 32'h4803);
        check("detector_on", {31'h0, detector_enable}, 32'h1);
        supply_low <= 1'b0;
        rd(CTRL);
        check("live_clear", rdata, 32'h4003);
        wr(`FPE_OFS_KEY, `FPE_KEY_FIRST);
        wr(`FPE_OFS_ADDR, 32'h0484);
        wr(`FPE_OFS_KEY, `FPE_KEY_SECOND);
        wr(CTRL, 32'hC003);
        rd(CTRL);
        check("start_locked", rdata, 32'h4003);
        rd(`FPE_OFS_ADDR);
        check("addr_rw", rdata, 32'h0484);
        $display("test select_and_lock done");

        wr(`FPE_OFS_IRQ_EN, 32'h1);
        for (int i = 0; i < 16; i++) begin
            run_op(i[3:0]);
            check("op_count", {24'h0, op_count}, {24'h0, n0} + (i inside {1, 3, 4, 5}));
            if (i inside {1, 3, 4, 5}) begin
                exp_a = (i == 1) ? 32'h0484 : (i == 3) ? 32'h0480 : (i == 4) ? 32'h0400 : 32'h0;
                check("op_seen", {28'h0, last_op}, i);
                check("addr_seen", last_addr, exp_a);
            end
        end
        rd(IST);
        check("irq_done", {rdata[2:0], irq}, 4'h3);
        wr(`FPE_OFS_IRQ_CLR, 32'h7);
        rd(IST);
        check("irq_clear", {rdata[2:0], irq}, 4'h0);
        wr(`FPE_OFS_IRQ_EN, 32'h0);
        run_op(4'h0);
        rd(IST);
        check("irq_masked", {rdata[2:0], irq}, 4'h2);
        $display("test codes_and_irq done");

        protect_pages <= 8'h02;
        for (int j = 0; j < 4; j++) begin
            run_op((j == 0) ? 4'h1 : 4'h2 + j[3:0]);
            check("prot_count", {24'h0, op_count}, {24'h0, n0});
            check("prot_err", {31'h0, rdata[13]}, 32'h1);
        end
        protect_pages <= 8'h00;
        run_op(4'h0);
        check("err_cleared", {30'h0, rdata[13:12]}, 32'h0);
        fail_en <= 1'b1;
        run_op(4'h1);
        check("fail_err", {31'h0, rdata[13]}, 32'h1);
        fail_en <= 1'b0;
        run_op(4'h0);
        lat <= 4'hC;
        supply_low <= 1'b1;
        run_op(4'h3);
        check("low_err", rdata[13:11], 3'b011);
        supply_low <= 1'b0;
        hang_en <= 1'b1;
        run_op(4'h4);
        check("timeout_err", {31'h0, rdata[13]}, 32'h1);
        hang_en <= 1'b0;
        $display("test errors done");

        device_reset <= 1'b1;
        @(posedge clock);
        device_reset <= 1'b0;
        rd(CTRL);
        check("dev_reset", rdata, 32'h3004);
        check("detector_off", {31'h0, detector_enable}, 32'h0);
        run_op(4'h0);
        check("lowerr_clear", {30'h0, rdata[13:12]}, 32'h0);
        $display("test device_reset done");
        end_sim();
    end
endmodule
